// >>> core/pmic_regs.svh
// register indices, field positions and reset values of the interrupt control
`ifndef PMIC_REGS_SVH
`define PMIC_REGS_SVH
`define PMIC_ADDR_W     18
`define PMIC_IC_IDX1    16'hFEBA
`define PMIC_IC_IDX2    16'hFECC
`define PMIC_IE_IDX1    16'hFEBC
`define PMIC_IE_IDX2    16'hFECE
`define PMIC_CTL_IDX1   16'hFEB6
`define PMIC_CTL_IDX2   16'hFEC8
`define PMIC_IC_RST     8'h41
`define PMIC_IE_RST     8'h00
`define PMIC_CTL_RST1   8'h40
`define PMIC_CTL_RST2   8'hC0
`define PMIC_B_REQ      0
`define PMIC_B_MGMT     1
`define PMIC_B_CTRL     2
`define PMIC_B_SHP_LO   3
`define PMIC_B_SHP_HI   5
`define PMIC_B_MPOL     6
`define PMIC_B_TRIG     7
`define PMIC_B_EME      7
`define PMIC_B_CPOL     6
`define PMIC_B_IRQE     0
`define PMIC_B_SCIE     1
`define PMIC_B_SMIE     2
`define PMIC_B_HW_REQUEST_ENABLE    3
`define PMIC_B_HW_CTRL_ENABLE    4
`define PMIC_B_HW_MGMT_ENABLE    5
`define PMIC_SHP_LEVEL  3'h0
`define PMIC_CNT_W      5
`endif

// >>> core/pmic_pkg.sv
// types shared by the power-management channel interrupt control
package pmic_pkg;
  typedef struct packed {
    logic ctrl;
    logic mgmt;
    logic request;
  } pmic_lines_s;
  typedef enum logic {
    SHP_IDLE,
    SHP_PULSE
  } pmic_shp_e;
  typedef logic [7:0] pmic_byte_t;
endpackage

// >>> core/pmic_top.sv
// interrupt line control for one power-management host channel
`include "pmic_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module pmic_top #(
  parameter bit CHANNEL_TWO = 1'b0
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [`PMIC_ADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic                     ibf_i,
  input  wire logic                     obf_i,
  input  wire logic                     obuf_wr_i,
  output pmic_pkg::pmic_lines_s         lines_o
);

  localparam logic [15:0] IC_IDX  =
    CHANNEL_TWO ? `PMIC_IC_IDX2 : `PMIC_IC_IDX1;
  localparam logic [15:0] IE_IDX  =
    CHANNEL_TWO ? `PMIC_IE_IDX2 : `PMIC_IE_IDX1;
  localparam logic [15:0] CTL_IDX =
    CHANNEL_TWO ? `PMIC_CTL_IDX2 : `PMIC_CTL_IDX1;
  localparam pmic_pkg::pmic_byte_t IC_RST  = `PMIC_IC_RST;
  localparam pmic_pkg::pmic_byte_t IE_RST  = `PMIC_IE_RST;
  localparam pmic_pkg::pmic_byte_t CTL_RST =
    CHANNEL_TWO ? `PMIC_CTL_RST2 : `PMIC_CTL_RST1;

  // word index to byte address, used for every register decode
  function automatic logic reg_hit(
    input logic [`PMIC_ADDR_W-1:0] addr,
    input logic [15:0]             idx
  );
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  // pulse length in core clocks; reserved codes give no pulse
  function automatic logic [`PMIC_CNT_W-1:0] shp_width(
    input logic [2:0] code
  );
    unique case (code)
      3'h1:    shp_width = 5'h01;
      3'h2:    shp_width = 5'h02;
      3'h3:    shp_width = 5'h04;
      3'h4:    shp_width = 5'h08;
      3'h5:    shp_width = 5'h10;
      default: shp_width = 5'h00;
    endcase
  endfunction

  // register state
  logic                    ic_req;
  logic                    ic_mgmt;
  logic                    ic_ctrl;
  logic [2:0]              ic_shp;
  logic                    ic_mpol;
  logic                    armed;
  logic [5:0]              ie;
  logic                    enhanced_mode_enable;
  logic                    cpol;
  logic                    ibf_q;
  pmic_pkg::pmic_shp_e     sh_state;
  logic [`PMIC_CNT_W-1:0]  sh_cnt;
  pmic_pkg::pmic_lines_s   next_lines;
  pmic_pkg::pmic_byte_t    rd_byte;

  // bus decode
  wire setup_ph = psel_i & ~penable_i;
  wire access_ph = psel_i & penable_i;
  wire hit_ic = reg_hit(paddr_i, IC_IDX);
  wire hit_ie = reg_hit(paddr_i, IE_IDX);
  wire hit_ctl = reg_hit(paddr_i, CTL_IDX);
  wire any_hit = hit_ic | hit_ie | hit_ctl;
  wire wr_ic = access_ph & pwrite_i & hit_ic;
  wire wr_ie = access_ph & pwrite_i & hit_ie;
  wire wr_ctl = access_ph & pwrite_i & hit_ctl;
  wire [7:0] wbyte = pwdata_i[7:0];
  wire arm_set = wr_ic & wbyte[`PMIC_B_TRIG];

  // enable fields
  wire irqe = ie[`PMIC_B_IRQE];
  wire scie = ie[`PMIC_B_SCIE];
  wire smie = ie[`PMIC_B_SMIE];
  wire hw_request_enable = ie[`PMIC_B_HW_REQUEST_ENABLE];
  wire hw_ctrl_enable = ie[`PMIC_B_HW_CTRL_ENABLE];
  wire hw_mgmt_enable = ie[`PMIC_B_HW_MGMT_ENABLE];

  // shaper
  wire pulse_mode = (ic_shp != `PMIC_SHP_LEVEL);
  wire [`PMIC_CNT_W-1:0] width = shp_width(ic_shp);
  wire sh_start = obuf_wr_i & pulse_mode & (width != 5'h00);
  wire sh_out = pulse_mode ? (sh_state == pmic_pkg::SHP_PULSE)
                           : obf_i;

  // one-shot ctrl on input buffer flag clear
  wire ibf_fall = ibf_q & ~ibf_i;
  wire fire = armed & ibf_fall & enhanced_mode_enable;

  // active levels before polarity; legacy forces all inactive
  wire req_src = hw_request_enable ? obf_i : ic_req;
  wire mgmt_src = hw_mgmt_enable ? sh_out : ic_mgmt;
  wire ctrl_src = (hw_ctrl_enable ? obf_i : ic_ctrl) | fire;
  wire req_act = enhanced_mode_enable & irqe & req_src;
  wire mgmt_act = enhanced_mode_enable & smie & mgmt_src;
  wire ctrl_act = enhanced_mode_enable & scie & ctrl_src;

  assign next_lines.request = req_act;
  assign next_lines.mgmt = mgmt_act ^ ic_mpol;
  assign next_lines.ctrl = ctrl_act ^ cpol;

  // readback of the fw bits shows the pins, trigger always zero
  wire [7:0] rd_ic = {1'b0, ic_mpol, ic_shp, lines_o.ctrl,
                      lines_o.mgmt, lines_o.request};
  wire [7:0] rd_ie = {2'b00, ie};
  wire [7:0] rd_ctl = {enhanced_mode_enable, cpol, 6'h00};
  assign rd_byte = hit_ic ? rd_ic :
                   hit_ie ? rd_ie :
                   hit_ctl ? rd_ctl : 8'h00;

  // zero wait states: read data is caught in the setup cycle
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph & ~any_hit;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_o <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ic_req  <= IC_RST[`PMIC_B_REQ];
      ic_mgmt <= IC_RST[`PMIC_B_MGMT];
      ic_ctrl <= IC_RST[`PMIC_B_CTRL];
      ic_shp  <= IC_RST[`PMIC_B_SHP_HI:`PMIC_B_SHP_LO];
      ic_mpol <= IC_RST[`PMIC_B_MPOL];
    end else if (wr_ic) begin
      ic_req  <= wbyte[`PMIC_B_REQ];
      ic_mgmt <= wbyte[`PMIC_B_MGMT];
      ic_ctrl <= wbyte[`PMIC_B_CTRL];
      ic_shp  <= wbyte[`PMIC_B_SHP_HI:`PMIC_B_SHP_LO];
      ic_mpol <= wbyte[`PMIC_B_MPOL];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ie <= IE_RST[5:0];
    end else if (wr_ie) begin
      ie <= wbyte[5:0];
    end
  end

  // on channel 2 the mode bit never leaves its reset value
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      enhanced_mode_enable  <= CTL_RST[`PMIC_B_EME];
      cpol <= CTL_RST[`PMIC_B_CPOL];
    end else if (wr_ctl) begin
      enhanced_mode_enable  <= CHANNEL_TWO | wbyte[`PMIC_B_EME];
      cpol <= wbyte[`PMIC_B_CPOL];
    end
  end

  // a new arm in the firing cycle wins so no request is lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      armed <= 1'b0;
      ibf_q <= 1'b0;
    end else begin
      ibf_q <= ibf_i;
      if (arm_set) begin
        armed <= 1'b1;
      end else if (fire) begin
        armed <= 1'b0;
      end
    end
  end

  // a write during a pulse restarts it at the full width
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sh_state <= pmic_pkg::SHP_IDLE;
      sh_cnt   <= 5'h00;
    end else if (sh_start) begin
      sh_state <= pmic_pkg::SHP_PULSE;
      sh_cnt   <= width - 5'h01;
    end else begin
      unique case (sh_state)
        pmic_pkg::SHP_IDLE: begin
          sh_cnt <= 5'h00;
        end
        pmic_pkg::SHP_PULSE: begin
          if (sh_cnt == 5'h00) begin
            sh_state <= pmic_pkg::SHP_IDLE;
          end else begin
            sh_cnt <= sh_cnt - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lines_o <= {1'b1, 1'b1, 1'b0};
    end else begin
      lines_o <= next_lines;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_legacy_lines_idle: assert property (
    !enhanced_mode_enable |=> !lines_o.request
  ) else $error("request line active in legacy mode");

  a_legacy_ignores_fw: assert property (
    !enhanced_mode_enable |=> (lines_o.mgmt == $past(ic_mpol)) &&
             (lines_o.ctrl == $past(cpol))
  ) else $error("control bits acted in legacy mode");

  a_fw_req_drive: assert property (
    enhanced_mode_enable && irqe && !hw_request_enable |=> lines_o.request == $past(ic_req)
  ) else $error("request line not from firmware bit");

  a_read_req_pin: assert property (
    setup_ph && hit_ic |=> prdata_o[`PMIC_B_REQ] == $past(lines_o.request)
  ) else $error("request readback not the pin");

  a_fw_mgmt_drive: assert property (
    enhanced_mode_enable && smie && !hw_mgmt_enable |=> lines_o.mgmt == ($past(ic_mgmt) ^ $past(ic_mpol))
  ) else $error("mgmt line not from firmware bit");

  a_read_mgmt_pin: assert property (
    setup_ph && hit_ic |=> prdata_o[`PMIC_B_MGMT] == $past(lines_o.mgmt)
  ) else $error("mgmt readback not the pin");

  a_fw_ctrl_drive: assert property (
    enhanced_mode_enable && scie && !hw_ctrl_enable && !fire |=>
      lines_o.ctrl == ($past(ic_ctrl) ^ $past(cpol))
  ) else $error("ctrl line not from firmware bit");

  a_read_ctrl_pin: assert property (
    setup_ph && hit_ic |=> prdata_o[`PMIC_B_CTRL] == $past(lines_o.ctrl)
  ) else $error("ctrl readback not the pin");

  a_level_mode_obf: assert property (
    enhanced_mode_enable && smie && hw_mgmt_enable && !pulse_mode |=>
      lines_o.mgmt == ($past(obf_i) ^ $past(ic_mpol))
  ) else $error("level shaper does not follow obf");

  a_pulse_two_high: assert property (
    obuf_wr_i && ic_shp == 3'h2 |=> (sh_state == pmic_pkg::SHP_PULSE) [*2]
  ) else $error("pulse not started on buffer write");

  a_pulse_two_end: assert property (
    obuf_wr_i && ic_shp == 3'h2 ##1 (!obuf_wr_i && ic_shp == 3'h2) [*2]
      |=> sh_state == pmic_pkg::SHP_IDLE
  ) else $error("two cycle pulse has wrong width");

  a_pulse_sixteen: assert property (
    obuf_wr_i && ic_shp == 3'h5 |=> sh_cnt == 5'h0F
  ) else $error("sixteen cycle pulse count wrong");

  a_mgmt_pol_legacy: assert property (
    !enhanced_mode_enable && ic_mpol |=> lines_o.mgmt
  ) else $error("mgmt polarity lost in legacy mode");

  a_trig_fires_ctrl: assert property (
    fire && scie |=> lines_o.ctrl == !$past(cpol)
  ) else $error("armed ctrl interrupt not issued");

  a_trig_reads_zero: assert property (
    setup_ph && hit_ic |=> !prdata_o[`PMIC_B_TRIG]
  ) else $error("trigger bit read back nonzero");

  a_hw_req_obf: assert property (
    enhanced_mode_enable && irqe && hw_request_enable |=> lines_o.request == $past(obf_i)
  ) else $error("hardware request not from obf");

  a_chan_two_eme: assert property (
    CHANNEL_TWO |-> enhanced_mode_enable
  ) else $error("channel 2 left enhanced mode");

  a_trig_disarms: assert property (
    fire && !arm_set |=> !armed
  ) else $error("trigger did not return idle");

  a_hw_ctrl_obf: assert property (
    enhanced_mode_enable && scie && hw_ctrl_enable && !fire |=>
      lines_o.ctrl == ($past(obf_i) ^ $past(cpol))
  ) else $error("hardware ctrl not from obf");

  a_reserved_no_pulse: assert property (
    obuf_wr_i && ic_shp > 3'h5 && sh_state == pmic_pkg::SHP_IDLE
      |=> sh_state == pmic_pkg::SHP_IDLE
  ) else $error("reserved shaper code made a pulse");

  c_pulse_mode: cover property (
    sh_start ##1 sh_state == pmic_pkg::SHP_PULSE
  );
  c_trig_fire: cover property (
    arm_set ##[1:20] fire
  );
  c_unmapped: cover property (
    pslverr_o
  );

  c_level_follow: cover property (
    hw_mgmt_enable && !pulse_mode && obf_i
  );

  c_legacy_pol: cover property (
    !enhanced_mode_enable && ic_mpol
  );

endmodule
`default_nettype wire

// >>> sim/pmic_host_model.sv
// host-side observer that counts pulses on the mgmt and ctrl interrupt lines
`timescale 1ns/10ps
`default_nettype none
module pmic_host_model (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire pmic_pkg::pmic_lines_s lines_i,
  output logic [7:0]                 mgmt_width_o,
  output logic [7:0]                 mgmt_pulses_o,
  output logic [7:0]                 ctrl_pulses_o
);
  logic [7:0] run;
  logic       mgmt_q;
  logic       ctrl_q;

  // widths are counted in core clocks, the host samples levels only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run           <= 8'h00;
      // both lines idle high after reset; a low start would fake an edge
      mgmt_q        <= 1'b1;
      ctrl_q        <= 1'b1;
      mgmt_width_o  <= 8'h00;
      mgmt_pulses_o <= 8'h00;
      ctrl_pulses_o <= 8'h00;
    end else begin
      mgmt_q <= lines_i.mgmt;
      ctrl_q <= lines_i.ctrl;
      run    <= lines_i.mgmt ? run + 8'h01 : 8'h00;
      if (mgmt_q && !lines_i.mgmt) begin
        mgmt_width_o  <= run;
        mgmt_pulses_o <= mgmt_pulses_o + 8'h01;
      end
      if (!ctrl_q && lines_i.ctrl) begin
        ctrl_pulses_o <= ctrl_pulses_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/pmic_top_test.sv
// self-checking bench for the channel interrupt line control
`include "pmic_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module pmic_top_test;
  logic                  clk_sys_i = 1'b0;
  logic                  rst_i     = 1'b1;
  logic                  psel      = 1'b0;
  logic                  penable   = 1'b0;
  logic                  pwrite    = 1'b0;
  logic [17:0]           paddr     = 18'h00000;
  logic [31:0]           pwdata    = 32'h00000000;
  logic                  input_buffer_full_flag       = 1'b0;
  logic                  output_buffer_full_flag       = 1'b0;
  logic                  obuf_wr   = 1'b0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  pmic_pkg::pmic_lines_s lines;
  logic [31:0]           prdata2;
  logic                  pready2;
  pmic_pkg::pmic_lines_s lines2;
  logic [31:0]           rd2;
  logic [7:0]            mw;
  logic [7:0]            mpc;
  logic [7:0]            cpc;
  logic [31:0]           rd32;
  logic                  er;
  logic [7:0]            pn;
  logic [7:0]            dn;
  logic [2:0]            v;
  logic                  mpl;
  logic                  cpl;
  int                    fail_count = 0;
  int                    num_checks = 0;
  int                    cycles     = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  pmic_top #(.CHANNEL_TWO(1'b0)) i_pmic_top (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ibf_i(input_buffer_full_flag), .obf_i(output_buffer_full_flag),
    .obuf_wr_i(obuf_wr), .lines_o(lines));

  pmic_host_model i_pmic_host_model (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .lines_i(lines),
    .mgmt_width_o(mw), .mgmt_pulses_o(mpc), .ctrl_pulses_o(cpc));

  // second channel shares the bus; only its own offsets hit
  pmic_top #(.CHANNEL_TWO(1'b1)) i_pmic_top_ch2 (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata2), .pready_o(pready2),
    .pslverr_o(), .ibf_i(input_buffer_full_flag), .obf_i(output_buffer_full_flag),
    .obuf_wr_i(obuf_wr), .lines_o(lines2));

  task automatic summarize;
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rd32    = prdata;
    rd2     = prdata2;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    check(rd32, {24'h000000, e});
  endtask

  task automatic pins(input logic [2:0] e);
    repeat (3) @(posedge clk_sys_i);
    check({29'h0, lines}, {29'h0, e});
  endtask

  task automatic ibf_drop;
    input_buffer_full_flag <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    input_buffer_full_flag <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdchk(`PMIC_IC_IDX1, 8'h46);
    rdchk(`PMIC_IE_IDX1, 8'h00);
    rdchk(`PMIC_CTL_IDX1, 8'h40);
    apb(1'b0, `PMIC_CTL_IDX2, 8'h00);
    check(rd2, 32'h000000C0);
    check({29'h0, lines2}, 32'h6);
    check({30'h0, pready, pready2}, 32'h3);
    wr(`PMIC_CTL_IDX2, 8'h00);
    apb(1'b0, `PMIC_CTL_IDX2, 8'h00);
    check(rd2, 32'h00000080);
    pins(3'b110);
    wr(16'h0010, 8'hFF);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 16'h0010, 8'h00);
    check(rd32, 32'h0);
    // legacy: only the polarity bits reach the pins, the ctrl line shows cpol
    wr(`PMIC_IE_IDX1, 8'h07);
    wr(`PMIC_IC_IDX1, 8'h07);
    pins(3'b100);
    rdchk(`PMIC_IC_IDX1, 8'h04);
    for (int k = 0; k < 32; k++) begin
      v   = k[2:0];
      mpl = k[3];
      cpl = k[4];
      wr(`PMIC_CTL_IDX1, {1'b1, cpl, 6'h00});
      wr(`PMIC_IC_IDX1, {1'b0, mpl, 3'b000, v});
      pins({v[2] ^ cpl, v[1] ^ mpl, v[0]});
      rdchk(`PMIC_IC_IDX1, {1'b0, mpl, 3'b000,
            v[2] ^ cpl, v[1] ^ mpl, v[0]});
    end
    wr(`PMIC_CTL_IDX1, 8'h80);
    wr(`PMIC_IE_IDX1, 8'h3F);
    wr(`PMIC_IC_IDX1, 8'h00);
    output_buffer_full_flag <= 1'b1;
    pins(3'b111);
    output_buffer_full_flag <= 1'b0;
    pins(3'b000);
    wr(`PMIC_IE_IDX1, 8'h24);
    for (int c = 1; c < 8; c++) begin
      wr(`PMIC_IC_IDX1, {2'b00, c[2:0], 3'b000});
      pn = mpc;
      obuf_wr <= 1'b1;
      @(posedge clk_sys_i);
      obuf_wr <= 1'b0;
      repeat (24) @(posedge clk_sys_i);
      dn = mpc - pn;
      check({24'h0, dn}, (c < 6) ? 32'h1 : 32'h0);
      if (c < 6) check({24'h0, mw}, 32'(1 << (c - 1)));
    end
    // arm the one-shot, then show it fires once and only when armed
    wr(`PMIC_IE_IDX1, 8'h02);
    wr(`PMIC_IC_IDX1, 8'h80);
    rdchk(`PMIC_IC_IDX1, 8'h00);
    pn = cpc;
    ibf_drop();
    ibf_drop();
    dn = cpc - pn;
    check({24'h0, dn}, 32'h1);
    // a zero written to the trigger after arming must not disarm it
    wr(`PMIC_IC_IDX1, 8'h80);
    wr(`PMIC_IC_IDX1, 8'h00);
    ibf_drop();
    dn = cpc - pn;
    check({24'h0, dn}, 32'h2);
    wr(`PMIC_CTL_IDX1, 8'h00);
    wr(`PMIC_IC_IDX1, 8'h80);
    ibf_drop();
    dn = cpc - pn;
    check({24'h0, dn}, 32'h2);
    summarize();
  end
endmodule
`default_nettype wire
